// >>> design/rss_core.sv
// execution core for rotate, literal subtract, sleep and return ops
//
// What this block does
// - rotate file register right through carry
// - destination zero to accumulator, one to file
// - eight-bit literal minus accumulator, two's complement
// - subtract to accumulator; carry, nibble carry, zero
// - sleep clears watchdog counter and prescaler
// - sleep clears power-down, sets time-out flag
// - sleep enters sleep state, stops oscillator
// - return loads literal, reloads pc from stack
`timescale 1ns/100ps
`default_nettype none
`include "rss_params.svh"

module rss_core
	import rss_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic wake,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic osc_run,
	output logic sleep_state
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		RSS_ST_RUN = 2'b00,
		RSS_ST_EXEC = 2'b01,
		RSS_ST_SLEEP = 2'b10
	} rss_state_t;

	rss_state_t state_reg;
	rss_instr_t instr_reg;
	logic [7:0] acc_reg;
	logic carry_reg;
	logic nibble_carry_reg;
	logic zero_reg;
	logic sleep_entered_flag_n_reg;
	logic expiry_flag_n_reg;
	logic [`RSS_WDOG_W-1:0] watchdog_counter_reg;
	logic [`RSS_PRE_W-1:0] prescaler_reg;
	logic [`RSS_PC_W-1:0] pc_reg;
	logic [`RSS_PC_W-1:0] tos_reg;
	logic [7:0] file_mem [0:`RSS_FILE_DEPTH-1];
	logic [7:0] src;
	rss_alu_t alu;
	logic wr_acc;
	logic wr_file;
	logic do_exec;
	logic bus_wr;
	logic bus_rd;
	logic file_hit;
	logic [`RSS_FILE_AW-1:0] bus_faddr;
	logic [31:0] rdata_next;
	logic err_next;

	// a write lands at the access edge, where ready is seen high
	assign bus_wr = psel && penable && pready && pwrite;
	assign bus_rd = psel && !penable && !pwrite;
	assign file_hit = (paddr[11:9] == 3'h1);
	assign bus_faddr = paddr[8:2];
	assign src = file_mem[instr_reg.faddr];
	assign do_exec = (state_reg == RSS_ST_EXEC);

	// ----------------------------------------------------------------
	// alu
	// ----------------------------------------------------------------
	rss_alu u_alu
	(
		.rot_sel(instr_reg.op == RSS_OP_ROTR),
		.src(src),
		.acc(acc_reg),
		.literal(instr_reg.literal),
		.carry_in(carry_reg),
		.res(alu)
	);

	// destination decode for the executing instruction
	always_comb
	begin
		wr_acc = 1'b0;
		wr_file = 1'b0;
		if (do_exec)
		begin
			case (instr_reg.op)
				RSS_OP_ROTR:
				begin
					wr_acc = !instr_reg.dest_file;
					wr_file = instr_reg.dest_file;
				end
				RSS_OP_LSUB: wr_acc = 1'b1;
				default:
				begin
					wr_acc = 1'b0;
					wr_file = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sequencer: writing the command register starts one execution
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= RSS_ST_RUN;
		else
		begin
			case (state_reg)
				RSS_ST_RUN:
					if (bus_wr && paddr == `RSS_OFF_CMD)
						state_reg <= RSS_ST_EXEC;
				RSS_ST_EXEC:
					if (instr_reg.op == RSS_OP_SLEEP)
						state_reg <= RSS_ST_SLEEP;
					else
						state_reg <= RSS_ST_RUN;
				RSS_ST_SLEEP:
					if (wake)
						state_reg <= RSS_ST_RUN;
				default: state_reg <= RSS_ST_RUN;
			endcase
		end
	end

	// instruction capture from the operand and command registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			instr_reg <= '0;
		else if (bus_wr && state_reg == RSS_ST_RUN)
		begin
			if (paddr == `RSS_OFF_OPND)
			begin
				instr_reg.literal <= pwdata[7:0];
				instr_reg.faddr <= pwdata[14:8];
				instr_reg.dest_file <= pwdata[16];
			end
			else if (paddr == `RSS_OFF_CMD)
				instr_reg.op <= rss_op_t'(pwdata[2:0]);
		end
	end

	// ----------------------------------------------------------------
	// accumulator and flags
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			acc_reg <= `RSS_ACC_RST;
		else if (wr_acc)
			acc_reg <= alu.result;
		else if (do_exec && instr_reg.op == RSS_OP_RETK)
			acc_reg <= instr_reg.literal;
		else if (bus_wr && paddr == `RSS_OFF_ACC && state_reg == RSS_ST_RUN)
			acc_reg <= pwdata[7:0];
	end

	// arithmetic flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			carry_reg <= 1'b0;
			nibble_carry_reg <= 1'b0;
			zero_reg <= 1'b0;
		end
		else if (do_exec && instr_reg.op == RSS_OP_ROTR)
			carry_reg <= alu.carry;
		else if (do_exec && instr_reg.op == RSS_OP_LSUB)
		begin
			carry_reg <= alu.carry;
			nibble_carry_reg <= alu.nibble_carry;
			zero_reg <= alu.zero;
		end
		else if (bus_wr && paddr == `RSS_OFF_STAT && state_reg == RSS_ST_RUN)
		begin
			carry_reg <= pwdata[`RSS_STAT_C];
			nibble_carry_reg <= pwdata[`RSS_STAT_DC];
			zero_reg <= pwdata[`RSS_STAT_Z];
		end
	end

	// power status bits, both read as one after reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sleep_entered_flag_n_reg <= 1'b1;
			expiry_flag_n_reg <= 1'b1;
		end
		else if (do_exec && instr_reg.op == RSS_OP_SLEEP)
		begin
			sleep_entered_flag_n_reg <= 1'b0;
			expiry_flag_n_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// watchdog counter and prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescaler_reg <= '0;
			watchdog_counter_reg <= '0;
		end
		else if (do_exec && instr_reg.op == RSS_OP_SLEEP)
		begin
			prescaler_reg <= '0;
			watchdog_counter_reg <= '0;
		end
		else if (state_reg != RSS_ST_SLEEP)
		begin
			prescaler_reg <= prescaler_reg + 1'b1;
			if (&prescaler_reg)
				watchdog_counter_reg <= watchdog_counter_reg + 1'b1;
		end
	end

	// program counter and top of stack
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pc_reg <= '0;
			tos_reg <= '0;
		end
		else if (do_exec && instr_reg.op == RSS_OP_RETK)
			pc_reg <= tos_reg;
		else if (bus_wr && paddr == `RSS_OFF_TOS && state_reg == RSS_ST_RUN)
			tos_reg <= pwdata[`RSS_PC_W-1:0];
	end

	// ----------------------------------------------------------------
	// data-memory file
	// ----------------------------------------------------------------
	always_ff @(posedge pclk)
	begin
		if (wr_file)
			file_mem[instr_reg.faddr] <= alu.result;
		else if (bus_wr && file_hit && state_reg == RSS_ST_RUN)
			file_mem[bus_faddr] <= pwdata[7:0];
	end

	// ----------------------------------------------------------------
	// apb read mux and answer, one wait-free access phase
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		err_next = 1'b0;
		if (file_hit)
			rdata_next = {24'h00_0000, file_mem[bus_faddr]};
		else
		begin
			case (paddr)
				`RSS_OFF_CMD: rdata_next = {29'h0, instr_reg.op};
				`RSS_OFF_OPND: rdata_next = {15'h0, instr_reg.dest_file,
					1'b0, instr_reg.faddr, instr_reg.literal};
				`RSS_OFF_ACC: rdata_next = {24'h00_0000, acc_reg};
				`RSS_OFF_STAT: rdata_next = {26'h0,
					state_reg == RSS_ST_SLEEP, expiry_flag_n_reg,
					sleep_entered_flag_n_reg, zero_reg,
					nibble_carry_reg, carry_reg};
				`RSS_OFF_WDOG: rdata_next = {16'h0000, prescaler_reg,
					watchdog_counter_reg};
				`RSS_OFF_PC: rdata_next = {21'h0, pc_reg};
				`RSS_OFF_TOS: rdata_next = {21'h0, tos_reg};
				default: err_next = 1'b1;
			endcase
		end
	end

	// registered answer presented in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && err_next;
			if (bus_rd)
				prdata <= rdata_next;
		end
	end

	// oscillator and sleep indication
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_run <= 1'b1;
			sleep_state <= 1'b0;
		end
		else if (do_exec && instr_reg.op == RSS_OP_SLEEP)
		begin
			osc_run <= 1'b0;
			sleep_state <= 1'b1;
		end
		else if (state_reg == RSS_ST_SLEEP && wake)
		begin
			osc_run <= 1'b1;
			sleep_state <= 1'b0;
		end
	end

endmodule : rss_core

`default_nettype wire

// >>> design/rss_params.svh
// constants for the rotate, subtract and sleep execution block
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define RSS_OFF_CMD 12'h000
`define RSS_OFF_OPND 12'h004
`define RSS_OFF_ACC 12'h008
`define RSS_OFF_STAT 12'h00c
`define RSS_OFF_WDOG 12'h010
`define RSS_OFF_PC 12'h014
`define RSS_OFF_TOS 12'h018
`define RSS_OFF_FILE 12'h200

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define RSS_STAT_C 0
`define RSS_STAT_DC 1
`define RSS_STAT_Z 2
`define RSS_STAT_PDN 3
`define RSS_STAT_TON 4
`define RSS_STAT_SLP 5
`define RSS_ACC_RST 8'h00
`define RSS_FILE_DEPTH 128
`define RSS_FILE_AW 7
`define RSS_PC_W 11
`define RSS_WDOG_W 8
`define RSS_PRE_W 8

`endif

// >>> design/rss_pkg.sv
// types for the rotate, subtract and sleep execution block
`default_nettype none

package rss_pkg;

	typedef enum logic [2:0]
	{
		RSS_OP_NONE = 3'b000,
		RSS_OP_ROTR = 3'b001,
		RSS_OP_LSUB = 3'b010,
		RSS_OP_SLEEP = 3'b011,
		RSS_OP_RETK = 3'b100
	} rss_op_t;

	// one decoded instruction
	typedef struct packed
	{
		rss_op_t op;
		logic dest_file;
		logic [6:0] faddr;
		logic [7:0] literal;
	} rss_instr_t;

	// flags and results out of the alu
	typedef struct packed
	{
		logic [7:0] result;
		logic carry;
		logic nibble_carry;
		logic zero;
	} rss_alu_t;

endpackage : rss_pkg

`default_nettype wire

// >>> design/rss_alu.sv
// combinational alu for rotate right and literal minus accumulator
`timescale 1ns/100ps
`default_nettype none

module rss_alu
	import rss_pkg::*;
(
	input wire logic rot_sel,
	input wire logic [7:0] src,
	input wire logic [7:0] acc,
	input wire logic [7:0] literal,
	input wire logic carry_in,
	output rss_alu_t res
);

	logic [8:0] diff;
	logic [4:0] ndiff;

	// nine-bit sum gives the inverted borrow directly as bit 8, five-bit nibble sum as bit 4
	assign diff = {1'b0, literal} + {1'b0, ~acc} + 9'h001;
	assign ndiff = {1'b0, literal[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

	// rotate or subtract select
	always_comb
	begin
		if (rot_sel)
		begin
			res.result = {carry_in, src[7:1]};
			res.carry = src[0];
			res.nibble_carry = 1'b0;
			res.zero = 1'b0;
		end
		else
		begin
			res.result = diff[7:0];
			res.carry = diff[8];
			res.nibble_carry = ndiff[4];
			res.zero = (diff[7:0] == 8'h00);
		end
	end

endmodule : rss_alu

`default_nettype wire

// >>> verif/rss_core_checker.sv
// port checker for the rotate, subtract and sleep core
`timescale 1ns/100ps
`default_nettype none
`include "rss_params.svh"

module rss_core_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic wake,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic osc_run,
	input wire logic sleep_state
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// setup cycle of a bus transfer
	logic setup;
	assign setup = psel && !penable;

	property p_ready;
		setup |=> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("no answer after setup");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("ready held too long");
	property p_err;
		setup && paddr >= 12'h01c && paddr < 12'h200 |=> pslverr && pready;
	endproperty
	a_err: assert property (p_err)
		else $error("unmapped address not refused");
	property p_sleep_enter;
		setup && pwrite && paddr == `RSS_OFF_CMD && pwdata[2:0] == 3'h3
			&& !sleep_state && !wake |-> ##[1:3] sleep_state;
	endproperty
	a_sleep_enter: assert property (p_sleep_enter)
		else $error("sleep not entered");
	property p_osc_stop;
		sleep_state |-> !osc_run;
	endproperty
	a_osc_stop: assert property (p_osc_stop)
		else $error("oscillator runs in sleep");
	property p_sleep_stay;
		sleep_state && !wake |=> sleep_state;
	endproperty
	a_sleep_stay: assert property (p_sleep_stay)
		else $error("sleep left without wake");
	property p_stat_sleep;
		pready && !pwrite && $past(sleep_state) && paddr == `RSS_OFF_STAT
			|-> prdata[4:3] == 2'b10;
	endproperty
	a_stat_sleep: assert property (p_stat_sleep)
		else $error("status flags wrong in sleep");
	property p_wdog_sleep;
		pready && !pwrite && $past(sleep_state) && paddr == `RSS_OFF_WDOG
			|-> prdata[15:0] == 16'h0000;
	endproperty
	a_wdog_sleep: assert property (p_wdog_sleep)
		else $error("watchdog not cleared in sleep");
endmodule : rss_core_checker

bind rss_core rss_core_checker u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .wake, .prdata, .pready, .pslverr, .osc_run,
	.sleep_state);
`default_nettype wire

// >>> verif/rotate_subtract_sleep_ops_tb_top.sv
// self-checking testbench for the rotate, subtract and sleep core
`timescale 1ns/100ps
`default_nettype none
`include "rss_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module rotate_subtract_sleep_ops_tb_top;
	import rss_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wake = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, osc_run, sleep_state, err;
	int miscompares = 0, n_compared = 0;
	// ----------------------------------------------------------------
	// clock, design and bus tasks
	// ----------------------------------------------------------------
	always #2 pclk = ~pclk;
	rss_core DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.wake, .prdata, .pready, .pslverr, .osc_run, .sleep_state);

	// one apb transfer, holds the request until ready is sampled high
	task apb(input int w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w[0];
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wrap_up;
		if (miscompares == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_rotate(input logic [6:0] f, input logic [7:0] v, input logic c,
		input logic dst);
		logic [11:0] fa;
		fa = 12'h200 + {3'h0, f, 2'b00};
		apb(1, fa, {24'h0, v});
		apb(1, `RSS_OFF_ACC, 32'h0);
		apb(1, `RSS_OFF_STAT, {31'h0, c});
		apb(1, `RSS_OFF_OPND, {15'h0, dst, 1'b0, f, 8'h00});
		apb(1, `RSS_OFF_CMD, 32'h1);
		apb(0, dst ? fa : `RSS_OFF_ACC, 32'h0);
		`CHK(rd[7:0], {c, v[7:1]})
		apb(0, dst ? `RSS_OFF_ACC : fa, 32'h0);
		`CHK(rd[7:0], dst ? 8'h00 : v)
		apb(0, `RSS_OFF_STAT, 32'h0);
		`CHK(rd[0], v[0])
	endtask : t_rotate

	task t_sub(input logic [7:0] k, input logic [7:0] w);
		apb(1, `RSS_OFF_ACC, {24'h0, w});
		apb(1, `RSS_OFF_OPND, {24'h0, k});
		apb(1, `RSS_OFF_CMD, 32'h2);
		apb(0, `RSS_OFF_ACC, 32'h0);
		`CHK(rd[7:0], k - w)
		apb(0, `RSS_OFF_STAT, 32'h0);
		`CHK(rd[2:0], {k == w, w[3:0] <= k[3:0], w <= k})
	endtask : t_sub

	task t_retk;
		apb(1, `RSS_OFF_TOS, 32'h123);
		apb(1, `RSS_OFF_OPND, 32'h5a);
		apb(1, `RSS_OFF_CMD, 32'h4);
		apb(0, `RSS_OFF_ACC, 32'h0);
		`CHK(rd[7:0], 8'h5a)
		apb(0, `RSS_OFF_PC, 32'h0);
		`CHK(rd[10:0], 11'h123)
		apb(0, 12'h100, 32'h0);
		`CHK(err, 1'b1)
	endtask : t_retk

	task t_sleep;
		apb(0, `RSS_OFF_STAT, 32'h0);
		`CHK(rd[4:3], 2'b11)
		apb(1, `RSS_OFF_CMD, 32'h3);
		repeat (2) @(posedge pclk);
		`CHK(sleep_state, 1'b1)
		`CHK(osc_run, 1'b0)
		apb(0, `RSS_OFF_STAT, 32'h0);
		`CHK(rd[4:3], 2'b10)
		apb(0, `RSS_OFF_WDOG, 32'h0);
		`CHK(rd[15:0], 16'h0000)
		wake <= 1'b1;
		repeat (4) @(posedge pclk);
		wake <= 1'b0;
		`CHK(sleep_state, 1'b0)
	endtask : t_sleep
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_rotate(7'd5, 8'he6, 1'b0, 1'b0);
		t_rotate(7'd127, 8'h81, 1'b1, 1'b1);
		t_sub(8'h05, 8'h05);
		t_sub(8'h03, 8'h05);
		t_sub(8'h10, 8'h01);
		t_sub(8'hff, 8'h00);
		t_sub(8'h00, 8'hff);
		t_retk;
		repeat (20) @(posedge pclk);
		t_sleep;
		wrap_up;
	end
	initial
	begin
		#20000;
		miscompares++;
		wrap_up;
	end
endmodule : rotate_subtract_sleep_ops_tb_top
`default_nettype wire
